// *** hdl/stepper_defines.svh ***
// Offsets, field positions, reset values and timing counts of the stepper supervisor
`ifndef STEPPER_DEFINES_SVH
`define STEPPER_DEFINES_SVH

// Clock and timing
`define CLK_HZ 32'h0262_5a00
`define MS_PER_S 32'h0000_03e8
`define IDLE_TIME_MS 32'h0000_03e8
`define IDLE_CYCLES (`IDLE_TIME_MS * (`CLK_HZ / `MS_PER_S))
`define BLINK_TIME_MS 32'h0000_0032
`define BLINK_CYCLES (`BLINK_TIME_MS * (`CLK_HZ / `MS_PER_S))

// Over-temperature threshold in degrees Celsius (90)
`define OVER_TEMP_C 8'h5a

// Displacement per pulse at the coarsest resolution code
`define STEP_SIZE_MAX 4'h8

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_IRQ_STAT 8'h08
`define REG_IRQ_MASK 8'h0c
`define REG_POSITION 8'h10

// Control fields and reset value
`define CTRL_POL 0
`define CTRL_IDLE0 1
`define CTRL_DUAL 2
`define CTRL_RES_LSB 4
`define CTRL_RST 32'h0000_0001

// Status fields
`define STAT_DRV_EN 3
`define STAT_DIS 4
`define STAT_IDLE 5

// Fault vector bits
`define FLT_OT 0
`define FLT_IL 1
`define FLT_SH 2

// Interrupt bits
`define IRQ_FAULT 0
`define IRQ_IDLE 1

`endif

// *** hdl/stepper_pkg.sv ***
// Types shared by the stepper supervisor modules
package stepper_pkg;
  typedef enum logic [3:0]
  {
    DRV_RUN = 4'b0001,
    DRV_IDLE = 4'b0010,
    DRV_DIS = 4'b0100,
    DRV_FAULT = 4'b1000
  } drv_state_e;
  typedef logic [2:0] fault_vec_t;
  typedef logic [1:0] res_code_t;
  typedef logic [7:0] temp_t;
  typedef logic [3:0] step_size_t;
endpackage

// *** hdl/sup_if.sv ***
// Internal carrier between supervisor core, fault latch and pulse decoder
`timescale 1ns/1ps
`default_nettype none
interface sup_if;
  logic fault_clr;
  logic [2:0] fault_vec;
  logic fault_new;
  logic fmt_dual;
  logic [1:0] res_code;
  logic step_evt;
  logic step_dir;
  logic [3:0] step_size;
  modport flt (input fault_clr, output fault_vec, fault_new);
  modport pls (input fmt_dual, res_code, output step_evt, step_dir, step_size);
  modport core (output fault_clr, fmt_dual, res_code,
                input fault_vec, fault_new, step_evt, step_dir, step_size);
endinterface
`default_nettype wire

// *** hdl/fault_latch_unit.sv ***
// Fault input synchroniser and latch
`timescale 1ns/1ps
`default_nettype none
`include "stepper_defines.svh"
module fault_latch_unit
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire stepper_pkg::temp_t i_temp_c,
  input wire logic i_interlock_open,
  input wire logic i_phase_short,
  input wire logic i_case_short,
  sup_if.flt sif
);
  import stepper_pkg::*;

  typedef struct packed {
    fault_vec_t sync1;
    fault_vec_t sync2;
    fault_vec_t lat;
    logic new_evt;
  } flt_s;

  flt_s st_r;
  flt_s st_nxt;
  fault_vec_t raw;

  always_comb
  begin
    st_nxt = st_r;
    raw = '0;
    raw[`FLT_OT] = i_temp_c > `OVER_TEMP_C;
    raw[`FLT_IL] = i_interlock_open;
    raw[`FLT_SH] = i_phase_short | i_case_short;
    st_nxt.sync1 = raw;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.lat = sif.fault_clr ? st_r.sync2 : (st_r.lat | st_r.sync2);
    st_nxt.new_evt = |(st_r.sync2 & ~st_r.lat);
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign sif.fault_vec = st_r.lat;
  assign sif.fault_new = st_r.new_evt;

  property p_over_temp;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_temp_c > `OVER_TEMP_C) |-> ##3 sif.fault_vec[`FLT_OT];
  endproperty
  a_over_temp: assert property (p_over_temp) else $error("over-temp not latched");

  property p_interlock;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    i_interlock_open |-> ##3 sif.fault_vec[`FLT_IL];
  endproperty
  a_interlock: assert property (p_interlock) else $error("interlock not latched");

  property p_short;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_phase_short || i_case_short) |-> ##3 sif.fault_vec[`FLT_SH];
  endproperty
  a_short: assert property (p_short) else $error("short not latched");

  property p_sync_delay;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    sif.fault_new |-> $past(|raw, 3);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("fault without cause");

  for (genvar i = 0; i < 3; i++)
  begin : g_hold
    property p_hold;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (!sif.fault_clr && st_r.lat[i]) |=> st_r.lat[i];
    endproperty
    a_hold: assert property (p_hold) else $error("fault dropped without clear");
  end
endmodule
`default_nettype wire

// *** hdl/step_pulse_decoder.sv ***
// Directional pulse format decoder and resolution scaling
`timescale 1ns/1ps
`default_nettype none
`include "stepper_defines.svh"
module step_pulse_decoder
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_pulse_a,
  input wire logic i_pulse_b,
  sup_if.pls sif
);
  import stepper_pkg::*;

  typedef struct packed {
    logic a_prev;
    logic b_prev;
    logic evt;
    logic dir;
    step_size_t size;
  } dec_s;

  dec_s st_r;
  dec_s st_nxt;
  logic rise_a;
  logic rise_b;

  always_comb
  begin
    st_nxt = st_r;
    rise_a = i_pulse_a & ~st_r.a_prev;
    rise_b = i_pulse_b & ~st_r.b_prev;
    st_nxt.a_prev = i_pulse_a;
    st_nxt.b_prev = i_pulse_b;
    st_nxt.size = `STEP_SIZE_MAX >> sif.res_code;
    if (sif.fmt_dual)
    begin
      st_nxt.evt = rise_a ^ rise_b;
      if (rise_a ^ rise_b)
        st_nxt.dir = rise_a;
    end
    else
    begin
      st_nxt.evt = rise_a;
      st_nxt.dir = i_pulse_b;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign sif.step_evt = st_r.evt;
  assign sif.step_dir = st_r.dir;
  assign sif.step_size = st_r.size;

  property p_step_dir;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (!sif.fmt_dual && i_pulse_a && !st_r.a_prev)
      |=> sif.step_evt && (sif.step_dir == $past(i_pulse_b));
  endproperty
  a_step_dir: assert property (p_step_dir) else $error("step/dir pulse lost");

  property p_dual_ccw;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (sif.fmt_dual && i_pulse_b && !st_r.b_prev && !(i_pulse_a && !st_r.a_prev))
      |=> sif.step_evt && !sif.step_dir;
  endproperty
  a_dual_ccw: assert property (p_dual_ccw) else $error("ccw pulse wrong");

  property p_size;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    1'b1 |=> sif.step_size == (`STEP_SIZE_MAX >> $past(sif.res_code));
  endproperty
  a_size: assert property (p_size) else $error("step size wrong");
endmodule
`default_nettype wire

// *** hdl/stepper_fault_supervisor.sv ***
// Stepper drive supervisor: faults, disable, idle removal, indicator and APB registers
//
// Functional notes
// - The fault output conducts while no fault is latched and stops conducting on any fault.
// - Latched faults clear only on power-up reset or a toggle of the disable input.
// - A temperature above 90 C latches an over-temperature fault and stops the drive.
// - An open motor interlock loop latches an interlock fault.
// - A phase-to-phase or phase-to-case short latches a motor-short fault.
// - The indicator is red while a fault is latched and otherwise blinks green on pulses.
// - With the zero-percent idle option, current is removed after one second without pulses.
// - The disable polarity switch picks whether the energised or de-energised input disables.
// - Each input pulse moves the motor by an amount set by the step resolution code.
// - The two inputs are read as pulse pair or step plus direction as configured.
// - While disable is active, all motor current is removed.
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "stepper_defines.svh"
module stepper_fault_supervisor
#(
  parameter int unsigned IDLE_CYCLES = `IDLE_CYCLES,
  parameter int unsigned BLINK_CYCLES = `BLINK_CYCLES
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_pulse_a,
  input wire logic i_pulse_b,
  input wire logic i_disable_in,
  input wire stepper_pkg::temp_t i_temp_c,
  input wire logic i_interlock_open,
  input wire logic i_phase_short,
  input wire logic i_case_short,
  output logic o_fault_conduct,
  output logic o_led_red,
  output logic o_led_green,
  output logic o_drive_en,
  output logic o_micro_step,
  output logic o_micro_dir,
  output stepper_pkg::step_size_t o_micro_size,
  output logic o_irq
);
  import stepper_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    drv_state_e state;
    logic disable_polarity_switch;
    logic idle_current_zero_option;
    logic dual_pulse_format;
    res_code_t res;
    logic dis_prev;
    logic [31:0] idle_cnt;
    logic [31:0] blink_cnt;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [31:0] pos;
    logic [31:0] prdata;
    logic slverr;
    logic irq;
    logic fault_ok;
    logic led_red;
    logic led_green;
    logic drv_en;
    logic mstep;
    logic mdir;
    step_size_t msize;
  } top_s;

  localparam top_s RST_VAL = '{state: DRV_DIS, disable_polarity_switch: 1'b1, default: '0};

  top_s st_r;
  top_s st_nxt;
  sup_if sif ();

  logic dis_act;
  logic any_fault;
  logic apb_setup;
  logic apb_access;
  logic idle_enter;
  logic [31:0] rd_val;
  logic [1:0] irq_ev;
  logic [1:0] irq_clr;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  fault_latch_unit u_fault
  (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_temp_c(i_temp_c),
    .i_interlock_open(i_interlock_open),
    .i_phase_short(i_phase_short),
    .i_case_short(i_case_short),
    .sif(sif.flt)
  );

  step_pulse_decoder u_pulse
  (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_pulse_a(i_pulse_a),
    .i_pulse_b(i_pulse_b),
    .sif(sif.pls)
  );

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic addr_mapped(input logic [7:0] addr);
    addr_mapped = (addr == `REG_CTRL) || (addr == `REG_STATUS) ||
                  (addr == `REG_IRQ_STAT) || (addr == `REG_IRQ_MASK) ||
                  (addr == `REG_POSITION);
  endfunction

  // ----------------------------------------------------------------
  // Disable polarity and fault clear
  // ----------------------------------------------------------------
  assign dis_act = st_r.disable_polarity_switch ? i_disable_in : ~i_disable_in;
  assign sif.fault_clr = dis_act & ~st_r.dis_prev;
  assign sif.fmt_dual = st_r.dual_pulse_format;
  assign sif.res_code = st_r.res;
  assign any_fault = |sif.fault_vec;
  assign apb_setup = i_psel & ~i_penable;
  assign apb_access = i_psel & i_penable;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    idle_enter = 1'b0;
    rd_val = '0;
    irq_clr = '0;
    st_nxt.dis_prev = dis_act;

    // Drive state
    if (any_fault)
      st_nxt.state = DRV_FAULT;
    else if (dis_act)
      st_nxt.state = DRV_DIS;
    else
    begin
      unique case (st_r.state)
        DRV_RUN:
        begin
          if (st_r.idle_current_zero_option && !sif.step_evt &&
              st_r.idle_cnt == IDLE_CYCLES - 1)
          begin
            st_nxt.state = DRV_IDLE;
            idle_enter = 1'b1;
          end
        end
        DRV_IDLE:
        begin
          if (sif.step_evt || !st_r.idle_current_zero_option)
            st_nxt.state = DRV_RUN;
        end
        DRV_DIS, DRV_FAULT:
          st_nxt.state = DRV_RUN;
        default:
          st_nxt.state = DRV_DIS;
      endcase
    end

    // Idle timer counts cycles without a pulse
    if (sif.step_evt || st_r.state != DRV_RUN)
      st_nxt.idle_cnt = '0;
    else if (st_r.idle_cnt != IDLE_CYCLES - 1)
      st_nxt.idle_cnt = st_r.idle_cnt + 32'h1;

    // Step indicator stretch
    if (sif.step_evt)
      st_nxt.blink_cnt = BLINK_CYCLES;
    else if (st_r.blink_cnt != '0)
      st_nxt.blink_cnt = st_r.blink_cnt - 32'h1;

    // Motion output and position
    st_nxt.mstep = sif.step_evt && (st_r.state == DRV_RUN || st_r.state == DRV_IDLE) &&
                   !any_fault && !dis_act;
    if (sif.step_evt)
    begin
      st_nxt.mdir = sif.step_dir;
      st_nxt.msize = sif.step_size;
    end
    if (st_nxt.mstep)
    begin
      if (sif.step_dir)
        st_nxt.pos = st_r.pos + 32'(sif.step_size);
      else
        st_nxt.pos = st_r.pos - 32'(sif.step_size);
    end

    // Pin outputs
    st_nxt.fault_ok = !any_fault;
    st_nxt.led_red = any_fault;
    st_nxt.led_green = !any_fault && (sif.step_evt || st_r.blink_cnt != '0);
    st_nxt.drv_en = (st_nxt.state == DRV_RUN);

    // Register read mux
    unique case (i_paddr)
      `REG_CTRL:
      begin
        rd_val[`CTRL_POL] = st_r.disable_polarity_switch;
        rd_val[`CTRL_IDLE0] = st_r.idle_current_zero_option;
        rd_val[`CTRL_DUAL] = st_r.dual_pulse_format;
        rd_val[`CTRL_RES_LSB +: 2] = st_r.res;
      end
      `REG_STATUS:
      begin
        rd_val[2:0] = sif.fault_vec;
        rd_val[`STAT_DRV_EN] = st_r.drv_en;
        rd_val[`STAT_DIS] = dis_act;
        rd_val[`STAT_IDLE] = (st_r.state == DRV_IDLE);
      end
      `REG_IRQ_STAT:
        rd_val[1:0] = st_r.irq_stat;
      `REG_IRQ_MASK:
        rd_val[1:0] = st_r.irq_mask;
      `REG_POSITION:
        rd_val = st_r.pos;
      default:
        rd_val = '0;
    endcase

    // Setup phase captures read data and error
    if (apb_setup)
    begin
      st_nxt.prdata = rd_val;
      st_nxt.slverr = !addr_mapped(i_paddr);
    end

    // Access phase commits writes and read-clear
    if (apb_access && !st_r.slverr)
    begin
      if (i_pwrite && i_paddr == `REG_CTRL)
      begin
        st_nxt.disable_polarity_switch = i_pwdata[`CTRL_POL];
        st_nxt.idle_current_zero_option = i_pwdata[`CTRL_IDLE0];
        st_nxt.dual_pulse_format = i_pwdata[`CTRL_DUAL];
        st_nxt.res = i_pwdata[`CTRL_RES_LSB +: 2];
      end
      if (i_pwrite && i_paddr == `REG_IRQ_MASK)
        st_nxt.irq_mask = i_pwdata[1:0];
      if (!i_pwrite && i_paddr == `REG_IRQ_STAT)
        irq_clr = st_r.prdata[1:0];
    end

    // Sticky events, set wins over read-clear
    irq_ev = '0;
    irq_ev[`IRQ_FAULT] = sif.fault_new;
    irq_ev[`IRQ_IDLE] = idle_enter;
    st_nxt.irq_stat = (st_r.irq_stat & ~irq_clr) | irq_ev;
    st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st_r <= RST_VAL;
    else
      st_r <= st_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_prdata = st_r.prdata;
  assign o_pready = apb_access;
  assign o_pslverr = st_r.slverr;
  assign o_fault_conduct = st_r.fault_ok;
  assign o_led_red = st_r.led_red;
  assign o_led_green = st_r.led_green;
  assign o_drive_en = st_r.drv_en;
  assign o_micro_step = st_r.mstep;
  assign o_micro_dir = st_r.mdir;
  assign o_micro_size = st_r.msize;
  assign o_irq = st_r.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_fault_out;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    any_fault |=> !o_fault_conduct && !o_drive_en;
  endproperty
  a_fault_out: assert property (p_fault_out) else $error("fault output conducts");

  property p_healthy_out;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    !any_fault |=> o_fault_conduct;
  endproperty
  a_healthy_out: assert property (p_healthy_out) else $error("healthy drive reads faulted");

  property p_red_led;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    any_fault |=> o_led_red && !o_led_green;
  endproperty
  a_red_led: assert property (p_red_led) else $error("indicator not red on fault");

  property p_idle_time;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    $rose(st_r.state == DRV_IDLE)
      |-> $past(st_r.idle_cnt) == IDLE_CYCLES - 1 && $past(st_r.idle_current_zero_option)
          && !o_drive_en;
  endproperty
  a_idle_time: assert property (p_idle_time) else $error("idle removal timing wrong");

  property p_dis_low;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (!st_r.disable_polarity_switch && !i_disable_in) |=> !o_drive_en;
  endproperty
  a_dis_low: assert property (p_dis_low) else $error("de-energised disable ignored");

  property p_dis_high;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (st_r.disable_polarity_switch && i_disable_in) |=> !o_drive_en;
  endproperty
  a_dis_high: assert property (p_dis_high) else $error("energised disable ignored");

  property p_pos_step;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    st_r.mstep && st_r.mdir |-> st_r.pos == $past(st_r.pos) + 32'(st_r.msize);
  endproperty
  a_pos_step: assert property (p_pos_step) else $error("position not scaled");
endmodule
`default_nettype wire

// *** verif/indexer_model.sv ***
// Behavioural indexer driving the pulse pair and disable line
`timescale 1ns/1ps
`default_nettype none
module indexer_model
(
  input wire logic i_ref_clk,
  input wire logic i_start,
  input wire logic i_dual,
  input wire logic i_cw,
  input wire logic [3:0] i_count,
  input wire logic [3:0] i_gap,
  input wire logic i_dis_lvl,
  output logic o_pulse_a,
  output logic o_pulse_b,
  output logic o_disable,
  output logic o_busy
);
  assign o_disable = i_dis_lvl;
  // Pulses in the format the drive is set to, gap widens the low time
  initial
  begin
    o_pulse_a = 1'b0;
    o_pulse_b = 1'b0;
    o_busy = 1'b0;
    forever
    begin
      @(posedge i_ref_clk);
      if (i_start === 1'b1)
      begin
        o_busy <= 1'b1;
        o_pulse_b <= i_dual ? 1'b0 : i_cw;
        repeat (2) @(posedge i_ref_clk);
        for (int k = 0; k < i_count; k++)
        begin
          if (i_dual && !i_cw)
            o_pulse_b <= 1'b1;
          else
            o_pulse_a <= 1'b1;
          repeat (2) @(posedge i_ref_clk);
          o_pulse_a <= 1'b0;
          if (i_dual)
            o_pulse_b <= 1'b0;
          repeat (i_gap + 2) @(posedge i_ref_clk);
        end
        o_busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/stepper_fault_supervisor_tb.sv ***
// Self-checking bench of the stepper supervisor
`timescale 1ns/1ps
`default_nettype none
`include "stepper_defines.svh"
module stepper_fault_supervisor_tb;
  import stepper_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, conduct, red, green, drv, mstep, mdir, irq, busy, pa, pb, dis, e;
  step_size_t msize;
  temp_t temp = 8'h00;
  logic il = 1'b0;
  logic psh = 1'b0;
  logic csh = 1'b0;
  logic start = 1'b0;
  logic dual = 1'b0;
  logic cw = 1'b0;
  logic dlvl = 1'b0;
  logic saw_green = 1'b0;
  logic [3:0] cnt = 4'h1;
  logic [3:0] gap = 4'h0;
  int n_fail = 0;
  int checks = 0;
  int n_steps = 0;
  always #12.5 clk = ~clk;
  stepper_fault_supervisor #(.IDLE_CYCLES(20), .BLINK_CYCLES(4)) u_stepper_fault_supervisor
  (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_pulse_a(pa), .i_pulse_b(pb), .i_disable_in(dis),
    .i_temp_c(temp), .i_interlock_open(il), .i_phase_short(psh), .i_case_short(csh),
    .o_fault_conduct(conduct), .o_led_red(red), .o_led_green(green), .o_drive_en(drv),
    .o_micro_step(mstep), .o_micro_dir(mdir), .o_micro_size(msize), .o_irq(irq)
  );
  indexer_model u_indexer_model
  (
    .i_ref_clk(clk), .i_start(start), .i_dual(dual), .i_cw(cw), .i_count(cnt),
    .i_gap(gap), .i_dis_lvl(dlvl), .o_pulse_a(pa), .o_pulse_b(pb), .o_disable(dis),
    .o_busy(busy)
  );
  always @(posedge clk)
  begin
    if (mstep === 1'b1)
      n_steps++;
    if (green === 1'b1)
      saw_green <= 1'b1;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    int t;
    t = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && t < 50)
    begin
      @(posedge clk);
      t++;
    end
    chk(t < 50, 1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rq;
    logic re;
    apb(1'b1, a, d, rq, re);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] rq;
    logic re;
    apb(1'b0, a, 32'h0, rq, re);
    chk(rq & m, x);
  endtask
  task automatic send(input logic d, input logic c, input logic [3:0] n);
    int t;
    t = 0;
    dual <= d;
    cw <= c;
    cnt <= n;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    while (busy === 1'b1 && t < 400)
    begin
      @(posedge clk);
      t++;
    end
    chk(t < 400, 1);
    tick(6);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rdc(`REG_CTRL, 32'hffff_ffff, `CTRL_RST);
    rdc(`REG_IRQ_MASK, 32'hffff_ffff, 32'h0);
    wr(`REG_STATUS, 32'hffff_ffff);
    rdc(`REG_STATUS, 32'hffff_ffff, 32'h08);
    chk(conduct, 1);
    apb(1'b0, 8'h14, 32'h0, q, e);
    chk(e, 1);
    chk(q, 0);
  endtask
  task automatic t_faults;
    wr(`REG_IRQ_MASK, 32'h1);
    temp <= 8'h5a;
    tick(8);
    chk(conduct, 1);
    for (int k = 0; k < 4; k++)
    begin
      temp <= (k == 0) ? 8'h5b : 8'h5a;
      il <= (k == 1);
      psh <= (k == 2);
      csh <= (k == 3);
      tick(1);
      chk(conduct, 1);
      tick(6);
      chk(conduct, 0);
      chk(red, 1);
      chk(green, 0);
      chk(drv, 0);
      chk(irq, 1);
      rdc(`REG_STATUS, 32'h7, 32'h1 << ((k == 3) ? 2 : k));
      rdc(`REG_IRQ_STAT, 32'h1, 32'h1);
      tick(2);
      chk(irq, 0);
      temp <= 8'h5a;
      il <= 1'b0;
      psh <= 1'b0;
      csh <= 1'b0;
      tick(6);
      chk(conduct, 0);
      dlvl <= 1'b1;
      tick(4);
      dlvl <= 1'b0;
      tick(6);
      chk(conduct, 1);
      chk(red, 0);
    end
    il <= 1'b1;
    tick(6);
    dlvl <= 1'b1;
    tick(4);
    dlvl <= 1'b0;
    tick(6);
    chk(conduct, 0);
    il <= 1'b0;
    tick(4);
    rst_n <= 1'b0;
    tick(3);
    rst_n <= 1'b1;
    tick(4);
    chk(conduct, 1);
    rdc(`REG_STATUS, 32'h7, 32'h0);
  endtask
  task automatic t_pulses;
    logic [31:0] p0;
    logic [31:0] x;
    logic re;
    int s0;
    for (int k = 0; k < 16; k++)
    begin
      wr(`REG_CTRL, {26'h0, k[3:2], 1'b0, k[1], 2'h1});
      apb(1'b0, `REG_POSITION, 32'h0, p0, re);
      s0 = n_steps;
      gap <= k[3:0];
      send(k[1], k[0], 4'h3);
      chk(n_steps - s0, 3);
      chk(mdir, k[0]);
      chk(msize, 8 >> k[3:2]);
      x = k[0] ? p0 + 3 * (8 >> k[3:2]) : p0 - 3 * (8 >> k[3:2]);
      rdc(`REG_POSITION, 32'hffff_ffff, x);
    end
    chk(saw_green, 1);
  endtask
  task automatic t_idle;
    int s0;
    gap <= 4'h0;
    wr(`REG_IRQ_MASK, 32'h2);
    wr(`REG_CTRL, 32'h3);
    tick(30);
    chk(drv, 0);
    chk(irq, 1);
    rdc(`REG_STATUS, 32'h28, 32'h20);
    rdc(`REG_IRQ_STAT, 32'h2, 32'h2);
    s0 = n_steps;
    send(1'b0, 1'b1, 4'h1);
    chk(n_steps - s0, 1);
    chk(drv, 1);
    wr(`REG_CTRL, 32'h1);
  endtask
  task automatic t_disable;
    int s0;
    dlvl <= 1'b1;
    tick(4);
    chk(drv, 0);
    rdc(`REG_STATUS, 32'h18, 32'h10);
    s0 = n_steps;
    send(1'b0, 1'b1, 4'h2);
    chk(n_steps - s0, 0);
    wr(`REG_CTRL, 32'h0);
    tick(4);
    chk(drv, 1);
    dlvl <= 1'b0;
    tick(4);
    chk(drv, 0);
    dlvl <= 1'b1;
    tick(4);
    chk(drv, 1);
  endtask
  task automatic conclude;
    if (n_fail == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    tick(5);
    rst_n <= 1'b1;
    tick(4);
    t_reset;
    t_faults;
    t_pulses;
    t_idle;
    t_disable;
    conclude;
  end
  initial
  begin
    #(25 * 40000);
    n_fail++;
    conclude;
  end
endmodule
`default_nettype wire
